//--- eis_pkg.sv
// Constants for the external interrupt source select, subnode and trap entry block.
// Assumes a single hclk domain and an AHB-Lite master with word transfers.
`default_nettype none

package eis_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  // Word indices; the byte address is four times the index
  localparam logic [15:0] EIS_SUBNODE_ADDR = 16'hF1DE;
  localparam logic [15:0] EIS_FAST0_ADDR   = 16'hFF88;
  localparam logic [15:0] EIS_FAST1_ADDR   = 16'hFF8A;
  localparam logic [15:0] EIS_SRCSEL_ADDR  = 16'hF1C4;
  localparam logic [15:0] EIS_EDGE_ADDR    = 16'hF1C0;
  localparam logic [15:0] EIS_STATUS_ADDR  = 16'hF1C8;

  // ----------------------------------------
  // Fields and resets
  // ----------------------------------------
  localparam int EIS_TK_REQ_BIT = 0;
  localparam int EIS_TK_EN_BIT  = 1;
  localparam int EIS_CS_REQ_BIT = 2;
  localparam int EIS_CS_EN_BIT  = 3;
  localparam logic [1:0] EIS_SEL_PIN = 2'h0;
  localparam logic [1:0] EIS_SEL_ALT = 2'h1;
  localparam logic [1:0] EIS_EDGE_OFF  = 2'h0;
  localparam logic [1:0] EIS_EDGE_RISE = 2'h1;
  localparam logic [1:0] EIS_EDGE_FALL = 2'h2;
  localparam logic [1:0] EIS_EDGE_ANY  = 2'h3;
  localparam logic [15:0] EIS_REG_RST  = 16'h0000;
  localparam logic [3:0]  EIS_LVL_TRAP = 4'hF;
  localparam logic [7:0]  EIS_SEG_ZERO = 8'h00;
  localparam logic [23:0] EIS_VEC_MAX  = 24'h0001FC;

  // ----------------------------------------
  // Timing in clock phases (two per clock)
  // ----------------------------------------
  localparam int EIS_SAMPLE_PHASES = 2;
  localparam int EIS_ARB_PHASES    = 8;
  localparam int EIS_ARB_CYCLES    = EIS_ARB_PHASES / EIS_SAMPLE_PHASES;
  localparam logic [1:0] EIS_ARB_LAST = 2'(EIS_ARB_CYCLES - 1);

  // ----------------------------------------
  // Trap entry states
  // ----------------------------------------
  typedef enum logic [2:0] {
    EIS_IDLE = 3'b000,
    EIS_PSW  = 3'b001,
    EIS_CSP  = 3'b010,
    EIS_IPP  = 3'b011,
    EIS_JUMP = 3'b100
  } eis_state_t;

endpackage

`default_nettype wire

//--- eis_trap_entry.sv
// Trap entry sequencer: picks a trap, pushes context, forms the vector.
// Assumes the core holds its request until the jump pulse.
`default_nettype none

module eis_trap_entry
  import eis_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        sw_trap_req,
  input  wire logic [6:0]  sw_trap_number,
  input  wire logic [7:0]  hw_trap_req,
  input  wire logic        segmented,
  input  wire logic [15:0] processor_status_word,
  input  wire logic [7:0]  code_segment_pointer,
  input  wire logic [15:0] instruction_pointer,
  output logic             trap_busy,
  output logic             push_valid,
  output logic [15:0]      push_data,
  output logic             jump_valid,
  output logic [23:0]      jump_vector,
  output logic [7:0]       new_segment,
  output logic [15:0]      new_status_word,
  output logic             cancel_instr
);

  // ----------------------------------------
  // Trap selection
  // ----------------------------------------
  // Lowest index is highest priority; bits 0-2 cancel, the rest complete.
  logic [2:0]  win_idx;
  logic        hw_any;
  always_comb begin
    win_idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (hw_trap_req[i]) begin
        win_idx = 3'(i);
      end
    end
  end
  assign hw_any = |hw_trap_req;

  eis_state_t  state_ff, nxt_state;
  logic        is_hw_ff;
  logic [2:0]  idx_ff;
  logic [6:0]  num_ff;
  logic [15:0] psw_ff;

  wire start = (state_ff == EIS_IDLE) && (hw_any || sw_trap_req);

  always_comb begin
    case (state_ff)
      EIS_IDLE: nxt_state = start ? EIS_PSW : EIS_IDLE;
      EIS_PSW:  nxt_state = segmented ? EIS_CSP : EIS_IPP;
      EIS_CSP:  nxt_state = EIS_IPP;
      EIS_IPP:  nxt_state = EIS_JUMP;
      EIS_JUMP: nxt_state = EIS_IDLE;
      default:  nxt_state = EIS_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= EIS_IDLE;
      is_hw_ff <= 1'b0;
      idx_ff   <= 3'h0;
      num_ff   <= 7'h00;
      psw_ff   <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      if (start) begin
        is_hw_ff <= hw_any;
        idx_ff   <= win_idx;
        num_ff   <= sw_trap_number;
        psw_ff   <= processor_status_word;
      end
    end
  end

  assign trap_busy    = (state_ff != EIS_IDLE);
  assign cancel_instr = start && hw_any && (win_idx < 3'h3);
  assign push_valid   = (state_ff == EIS_PSW) || (state_ff == EIS_CSP) ||
                        (state_ff == EIS_IPP);
  assign push_data    = (state_ff == EIS_PSW) ? psw_ff :
                        (state_ff == EIS_CSP) ? {8'h00, code_segment_pointer} :
                        instruction_pointer;
  assign jump_valid   = (state_ff == EIS_JUMP);
  // Vector word index times four stays inside 0 .. 01FC.
  assign jump_vector  = is_hw_ff ? {19'h00000, idx_ff, 2'h0} :
                        {15'h0000, num_ff, 2'h0};
  assign new_segment  = segmented ? EIS_SEG_ZERO : code_segment_pointer;
  assign new_status_word = is_hw_ff ? {psw_ff[15:12] | EIS_LVL_TRAP, psw_ff[11:0]}
                                    : psw_ff;

endmodule // eis_trap_entry

`default_nettype wire

//--- eis_top.sv
// Source select, edge detection, subnode control and trap entry.
// Assumes an AHB-Lite master and word-aligned single transfers.
//
// The AHB-Lite interface to the registers was left to the implementer.
`default_nettype none

module eis_top
  import eis_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        fast_irq_pin0,
  input  wire logic        fast_irq_pin1,
  input  wire logic [7:2]  port_pin_in,
  input  wire logic        async_serial_receive_in,
  input  wire logic        sync_serial_receive_in,
  input  wire logic        sync_serial_clock_in,
  input  wire logic        usb_suspend_event,
  input  wire logic        rtc_event,
  input  wire logic        timekeeper_overflow_irq,
  input  wire logic        clock_supervision_irq,
  output logic             shared_peripheral_node,
  output logic [7:0]       fast_irq_request,
  output logic             fast_irq0_pending,
  output logic             fast_irq1_pending,
  input  wire logic        sw_trap_req,
  input  wire logic [6:0]  sw_trap_number,
  input  wire logic [7:0]  hw_trap_req,
  input  wire logic        segmented,
  input  wire logic [15:0] processor_status_word,
  input  wire logic [7:0]  code_segment_pointer,
  input  wire logic [15:0] instruction_pointer,
  output logic             trap_busy,
  output logic             push_valid,
  output logic [15:0]      push_data,
  output logic             jump_valid,
  output logic [23:0]      jump_vector,
  output logic [7:0]       new_segment,
  output logic [15:0]      new_status_word,
  output logic             cancel_instr
);

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  // Zero wait states; every access is OKAY, unmapped reads return zero.
  // Word-indexed map, so low address bits are ignored.
  logic        wr_pend_ff;
  logic [15:0] wr_addr_ff;
  wire  addr_ok = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 16'h0000;
    end else begin
      wr_pend_ff <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr_ff <= haddr[17:2];
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  wire [15:0] wd       = hwdata[15:0];
  wire        wr_sub   = wr_pend_ff && (wr_addr_ff == EIS_SUBNODE_ADDR);
  wire        wr_f0    = wr_pend_ff && (wr_addr_ff == EIS_FAST0_ADDR);
  wire        wr_f1    = wr_pend_ff && (wr_addr_ff == EIS_FAST1_ADDR);
  wire        wr_sel   = wr_pend_ff && (wr_addr_ff == EIS_SRCSEL_ADDR);
  wire        wr_edge  = wr_pend_ff && (wr_addr_ff == EIS_EDGE_ADDR);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0] src_sel_ff;
  logic [15:0] edge_ctl_ff;
  logic [15:0] fast0_ctl_ff;
  logic [15:0] fast1_ctl_ff;
  logic [1:0]  sub_en_ff;
  logic [1:0]  sub_req_ff;

  // Fields 0, 1 and 6 are kept by software at 00; hardware trusts it.
  // Other codes are stored but only 01 selects the alternate.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_sel_ff   <= EIS_REG_RST;
      edge_ctl_ff  <= EIS_REG_RST;
      fast0_ctl_ff <= EIS_REG_RST;
      fast1_ctl_ff <= EIS_REG_RST;
      sub_en_ff    <= 2'h0;
    end else begin
      if (wr_sel) src_sel_ff <= wd;
      if (wr_edge) edge_ctl_ff <= wd;
      if (wr_f0) fast0_ctl_ff <= wd;
      if (wr_f1) fast1_ctl_ff <= wd;
      if (wr_sub) sub_en_ff <= {wd[EIS_CS_EN_BIT], wd[EIS_TK_EN_BIT]};
    end
  end

  // ----------------------------------------
  // Subnode request flags
  // ----------------------------------------
  // Per-bit: a hardware set in the same cycle as a write wins.
  logic [1:0] sub_set;
  logic [1:0] sub_wr_val;
  assign sub_set    = {clock_supervision_irq, timekeeper_overflow_irq};
  assign sub_wr_val = {wd[EIS_CS_REQ_BIT], wd[EIS_TK_REQ_BIT]};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sub_req_ff <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (sub_set[i]) begin
          sub_req_ff[i] <= 1'b1;
        end else if (wr_sub) begin
          sub_req_ff[i] <= sub_wr_val[i];
        end
      end
    end
  end

  assign shared_peripheral_node = |(sub_req_ff & sub_en_ff);

  // ----------------------------------------
  // Source selection and edge detection
  // ----------------------------------------
  logic [7:0] alt_src;
  logic [7:0] pin_src;
  logic [7:0] chan_in;
  assign alt_src = {rtc_event, 1'b0, usb_suspend_event, sync_serial_clock_in,
                    sync_serial_receive_in, async_serial_receive_in, 2'h0};
  assign pin_src = {port_pin_in, fast_irq_pin1, fast_irq_pin0};

  // Clock runs at one sample per cycle, i.e. every two phases.
  logic [7:0] samp_ff;
  logic [7:0] prev_ff;
  logic [7:0] hit_ff;
  logic [1:0] arb_cnt_ff;
  logic [7:0] fast_req_ff;
  logic [7:0] hit_now;
  wire        arb_tick = (arb_cnt_ff == EIS_ARB_LAST);

  genvar c;
  generate
    for (c = 0; c < 8; c++) begin : g_chan
      wire [1:0] sel  = src_sel_ff[2*c+1:2*c];
      wire [1:0] mode = edge_ctl_ff[2*c+1:2*c];
      assign chan_in[c] = (sel == EIS_SEL_ALT) ? alt_src[c] : pin_src[c];
      wire rise = samp_ff[c] && !prev_ff[c];
      wire fall = !samp_ff[c] && prev_ff[c];
      assign hit_now[c] = ((mode == EIS_EDGE_RISE) && rise) ||
                          ((mode == EIS_EDGE_FALL) && fall) ||
                          ((mode == EIS_EDGE_ANY) && (rise || fall));
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      samp_ff     <= 8'h00;
      prev_ff     <= 8'h00;
      hit_ff      <= 8'h00;
      arb_cnt_ff  <= 2'h0;
      fast_req_ff <= 8'h00;
    end else begin
      samp_ff    <= chan_in;
      prev_ff    <= samp_ff;
      arb_cnt_ff <= arb_cnt_ff + 2'h1;
      if (arb_tick) begin
        fast_req_ff <= hit_ff | hit_now;
        hit_ff      <= 8'h00;
      end else begin
        hit_ff <= hit_ff | hit_now;
      end
    end
  end

  assign fast_irq_request  = fast_req_ff;
  // Control words are kept for software; pending follows the request
  assign fast_irq0_pending = fast_req_ff[0];
  assign fast_irq1_pending = fast_req_ff[1];

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  logic [15:0] rd_val;
  wire [15:0] sub_rd = {12'h000, sub_en_ff[1], sub_req_ff[1], sub_en_ff[0],
                        sub_req_ff[0]};
  assign rd_val = (wr_addr_ff == EIS_SUBNODE_ADDR) ? sub_rd :
                  (wr_addr_ff == EIS_FAST0_ADDR)   ? fast0_ctl_ff :
                  (wr_addr_ff == EIS_FAST1_ADDR)   ? fast1_ctl_ff :
                  (wr_addr_ff == EIS_SRCSEL_ADDR)  ? src_sel_ff :
                  (wr_addr_ff == EIS_EDGE_ADDR)    ? edge_ctl_ff :
                  (wr_addr_ff == EIS_STATUS_ADDR)  ? {8'h00, fast_req_ff} : 16'h0000;
  assign hrdata = {16'h0000, rd_val};

  // ----------------------------------------
  // Trap entry
  // ----------------------------------------
  // Traps bypass the fast channel arbitration entirely.
  eis_trap_entry u_trap (
    .hclk                  (hclk),
    .hresetn               (hresetn),
    .sw_trap_req           (sw_trap_req),
    .sw_trap_number        (sw_trap_number),
    .hw_trap_req           (hw_trap_req),
    .segmented             (segmented),
    .processor_status_word (processor_status_word),
    .code_segment_pointer  (code_segment_pointer),
    .instruction_pointer   (instruction_pointer),
    .trap_busy             (trap_busy),
    .push_valid            (push_valid),
    .push_data             (push_data),
    .jump_valid            (jump_valid),
    .jump_vector           (jump_vector),
    .new_segment           (new_segment),
    .new_status_word       (new_status_word),
    .cancel_instr          (cancel_instr)
  );

endmodule // eis_top

`default_nettype wire

//--- eis_chk.sv
// Checker for eis_top: shared node, request timing, trap entry.
// Assumes it is bound to eis_top and sees only its ports.
`default_nettype none

module eis_chk
  import eis_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hwrite,
  input wire logic        shared_peripheral_node,
  input wire logic        timekeeper_overflow_irq,
  input wire logic        clock_supervision_irq,
  input wire logic [7:0]  fast_irq_request,
  input wire logic        trap_busy,
  input wire logic        push_valid,
  input wire logic [15:0] push_data,
  input wire logic [15:0] processor_status_word,
  input wire logic [15:0] instruction_pointer,
  input wire logic        jump_valid,
  input wire logic [23:0] jump_vector,
  input wire logic [7:0]  new_segment,
  input wire logic [15:0] new_status_word,
  input wire logic        segmented,
  input wire logic [6:0]  sw_trap_number,
  input wire logic [7:0]  hw_trap_req,
  input wire logic        cancel_instr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ------
  // Checks
  // ------
  chk_node_cause: assert property (
    $rose(shared_peripheral_node) |->
      $past(timekeeper_overflow_irq || clock_supervision_irq || hwrite))
    else $error("node rose with no cause");
  chk_first_push: assert property (
    $rose(trap_busy) |-> push_valid && push_data == processor_status_word)
    else $error("first push not status");
  chk_ip_last: assert property (
    jump_valid |-> $past(push_valid) && $past(push_data) == $past(instruction_pointer))
    else $error("jump without pointer push");
  chk_seg_zero: assert property (
    jump_valid && segmented |-> new_segment == EIS_SEG_ZERO)
    else $error("segment not zero");
  chk_hw_level: assert property (
    jump_valid && hw_trap_req != 8'h00 |-> new_status_word[15:12] == EIS_LVL_TRAP)
    else $error("level not raised");
  chk_sw_level: assert property (
    jump_valid && hw_trap_req == 8'h00 |-> new_status_word == processor_status_word)
    else $error("software trap changed status");
  chk_sw_vector: assert property (
    jump_valid && hw_trap_req == 8'h00 |->
      jump_vector == {15'h0000, sw_trap_number, 2'h0} && jump_vector <= EIS_VEC_MAX)
    else $error("software vector wrong");
  chk_top_trap: assert property (
    jump_valid && hw_trap_req[0] |-> jump_vector == 24'h000000)
    else $error("top trap not chosen");
  chk_req_stands: assert property (
    !$stable(fast_irq_request) |=> $stable(fast_irq_request) [*3])
    else $error("request changed too soon");
  chk_cancel_cause: assert property (
    cancel_instr |-> hw_trap_req[2:0] != 3'h0)
    else $error("cancel without cancelling trap");

  cov_sw_seg: cover property (jump_valid && segmented && hw_trap_req == 8'h00);
  cov_hw: cover property (jump_valid && hw_trap_req != 8'h00);
  cov_node: cover property ($rose(shared_peripheral_node));
endmodule // eis_chk

`default_nettype wire

//--- eis_core_model.sv
// Core-side model: raises trap requests, holds them until the jump.
// Assumes one command pulse per trap from the bench.
`default_nettype none

module eis_core_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       cmd_go,
  input  wire logic       cmd_sw,
  input  wire logic [6:0] cmd_num,
  input  wire logic [7:0] cmd_hw,
  input  wire logic       jump_valid,
  output logic            sw_trap_req,
  output logic [6:0]      sw_trap_number,
  output logic [7:0]      hw_trap_req
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_trap_req    <= 1'b0;
      sw_trap_number <= 7'h2A;
      hw_trap_req    <= 8'h00;
    end else if (jump_valid) begin
      // Operand released: never leave the old value visible
      sw_trap_req    <= 1'b0;
      sw_trap_number <= ~sw_trap_number;
      hw_trap_req    <= 8'h00;
    end else if (cmd_go) begin
      sw_trap_req    <= cmd_sw;
      sw_trap_number <= cmd_num;
      hw_trap_req    <= cmd_hw;
    end
  end
endmodule // eis_core_model

`default_nettype wire

//--- ext_irq_source_select_and_trap_entry_tb.sv
// Bench for eis_top: registers, edges, source select, subnode, traps.
// Assumes eis_pkg, eis_chk and eis_core_model are compiled first.
`default_nettype none

module ext_irq_source_select_and_trap_entry_tb import eis_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, hready;
  logic        fast_irq_pin0 = 1'b0, fast_irq_pin1 = 1'b0, segmented = 1'b0;
  logic        timekeeper_overflow_irq = 1'b0, clock_supervision_irq = 1'b0;
  logic        cmd_go = 1'b0, cmd_sw = 1'b0, hreadyout, hresp, shared_peripheral_node;
  logic        fast_irq0_pending, fast_irq1_pending, sw_trap_req, trap_busy;
  logic        push_valid, jump_valid, cancel_instr;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
  logic [7:2]  port_pin_in = 6'h00;
  logic [7:0]  alt = 8'h00, cmd_hw = 8'h00, code_segment_pointer = 8'h3C;
  logic [7:0]  fast_irq_request, hw_trap_req, new_segment;
  logic [6:0]  cmd_num = 7'h00, sw_trap_number;
  logic [15:0] processor_status_word = 16'h2A5C, instruction_pointer = 16'h1234;
  logic [15:0] push_data, new_status_word;
  logic [23:0] jump_vector;
  int          failures = 0, checks = 0;

  initial begin
    forever #4 hclk = ~hclk;
  end
  assign hready = hreadyout;
  eis_top uut (.*, .async_serial_receive_in(alt[2]), .sync_serial_receive_in(alt[3]),
    .sync_serial_clock_in(alt[4]), .usb_suspend_event(alt[5]), .rtc_event(alt[7]));
  eis_core_model core (.*);

  // -------
  // Helpers
  // -------
  task automatic cmp(input string what, input logic [31:0] exp, got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic rdy;
    int i;
    @(posedge hclk);
    for (i = 0; i < 16 && hreadyout !== 1'b1; i++) @(posedge hclk);
    if (i == 16) begin
      failures++;
      wrap_up();
    end
  endtask
  // Read data taken at the edge that ends the data phase
  task automatic bus(input logic w, input logic [15:0] a, d);
    haddr  <= {14'h0, a, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    rdy();
    htrans <= 2'h0;
    hwdata <= {16'h0000, d};
    rdy();
    rdv = hrdata;
    cmp("response", 32'h0, {31'h0, hresp});
  endtask
  task automatic rdc(input logic [15:0] a, input logic [31:0] e, input string what);
    bus(1'b0, a, 16'h0000);
    cmp(what, e, rdv);
  endtask
  // Long enough for sync, the 4-cycle frame and the request to fall again
  task automatic scan(output logic [7:0] s);
    s = 8'h00;
    repeat (16) begin
      @(posedge hclk);
      s |= {fast_irq_request[7:2], fast_irq1_pending, fast_irq0_pending};
    end
  endtask
  task automatic pulse_cs;
    clock_supervision_irq <= 1'b1;
    @(posedge hclk);
    clock_supervision_irq <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask

  // ---------
  // Scenarios
  // ---------
  task automatic t_regs;
    rdc(EIS_SUBNODE_ADDR, 32'h0, "subnode reset");
    bus(1'b1, EIS_FAST0_ADDR, 16'h00A5);
    bus(1'b1, EIS_FAST1_ADDR, 16'h005A);
    rdc(EIS_FAST0_ADDR, 32'h00A5, "fast0 control");
    rdc(EIS_FAST1_ADDR, 32'h005A, "fast1 control");
    rdc(16'hF1E0, 32'h0, "unmapped");
    $display("test regs done");
  endtask
  task automatic t_sub;
    bus(1'b1, EIS_SUBNODE_ADDR, 16'h0002);
    timekeeper_overflow_irq <= 1'b1;
    @(posedge hclk);
    timekeeper_overflow_irq <= 1'b0;
    repeat (2) @(posedge hclk);
    rdc(EIS_SUBNODE_ADDR, 32'h3, "tk flag");
    cmp("node tk", 32'h1, {31'h0, shared_peripheral_node});
    // Hardware set held across a write that clears the enable
    clock_supervision_irq <= 1'b1;
    bus(1'b1, EIS_SUBNODE_ADDR, 16'h0001);
    clock_supervision_irq <= 1'b0;
    rdc(EIS_SUBNODE_ADDR, 32'h5, "cs flag kept");
    cmp("node masked", 32'h0, {31'h0, shared_peripheral_node});
    bus(1'b1, EIS_SUBNODE_ADDR, 16'h0008);
    rdc(EIS_SUBNODE_ADDR, 32'h8, "flags cleared");
    pulse_cs();
    cmp("node cs", 32'h1, {31'h0, shared_peripheral_node});
    bus(1'b1, EIS_SUBNODE_ADDR, 16'h0000);
    $display("test subnode done");
  endtask
  task automatic t_edge;
    logic [7:0] r, f;
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      bus(1'b1, EIS_EDGE_ADDR, {12'h000, c, c});
      fast_irq_pin0 <= 1'b1;
      fast_irq_pin1 <= 1'b1;
      scan(r);
      fast_irq_pin0 <= 1'b0;
      fast_irq_pin1 <= 1'b0;
      scan(f);
      cmp("rising", {30'h0, {2{c[0]}}}, {30'h0, r[1:0]});
      cmp("falling", {30'h0, {2{c[1]}}}, {30'h0, f[1:0]});
    end
    $display("test edge done");
  endtask
  task automatic t_alt;
    logic [7:0] s;
    bus(1'b1, EIS_EDGE_ADDR, 16'h5555);
    bus(1'b1, EIS_SRCSEL_ADDR, 16'h4550);
    for (int i = 2; i < 8; i++) begin
      port_pin_in[i] <= 1'b1;
      scan(s);
      cmp("pin path", 32'(i == 6), {31'h0, s[i]});
      alt[i] <= 1'b1;
      scan(s);
      cmp("alt path", 32'(i != 6), {31'h0, s[i]});
      port_pin_in[i] <= 1'b0;
      alt[i] <= 1'b0;
    end
    $display("test alt done");
  endtask
  task automatic trap(input logic s, sg, input logic [6:0] n, input logic [7:0] hw,
                      input logic [23:0] ev, input logic [31:0] ep);
    int i;
    logic [31:0] p;
    logic        cx;
    p = 32'h0;
    cx = 1'b0;
    segmented <= sg;
    cmd_sw <= s;
    cmd_num <= n;
    cmd_hw <= hw;
    cmd_go <= 1'b1;
    @(posedge hclk);
    cmd_go <= 1'b0;
    for (i = 0; i < 20; i++) begin
      @(posedge hclk);
      if (i == 0) cx = cancel_instr;
      if (jump_valid === 1'b1) break;
      if (push_valid === 1'b1) p++;
    end
    if (i == 20) begin
      failures++;
      wrap_up();
    end
    cmp("vector", {8'h00, ev}, {8'h00, jump_vector});
    cmp("pushes", ep, p);
    cmp("cancel", {31'h0, hw[2:0] != 3'h0}, {31'h0, cx});
    cmp("status", hw != 8'h00 ? 32'hFA5C : 32'h2A5C, {16'h0, new_status_word});
    if (sg) cmp("segment", 32'h0, {24'h0, new_segment});
  endtask
  task automatic t_trap;
    trap(1'b1, 1'b1, 7'h7F, 8'h00, 24'h0001FC, 32'h3);
    trap(1'b1, 1'b0, 7'h05, 8'h00, 24'h000014, 32'h2);
    for (int k = 0; k < 8; k++) begin
      trap(1'b0, k[0], 7'h00, 8'(8'h01 << k), 24'(k * 4), 32'(2 + k % 2));
    end
    trap(1'b0, 1'b1, 7'h00, 8'h06, 24'h000004, 32'h3);
    trap(1'b1, 1'b0, 7'h11, 8'h80, 24'h00001C, 32'h2);
    $display("test trap done");
  endtask

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_sub();
    t_edge();
    t_alt();
    t_trap();
    wrap_up();
  end
endmodule // ext_irq_source_select_and_trap_entry_tb

bind eis_top eis_chk u_chk (
  .hclk                    (hclk),
  .hresetn                 (hresetn),
  .hwrite                  (hwrite),
  .shared_peripheral_node  (shared_peripheral_node),
  .timekeeper_overflow_irq (timekeeper_overflow_irq),
  .clock_supervision_irq   (clock_supervision_irq),
  .fast_irq_request        (fast_irq_request),
  .trap_busy               (trap_busy),
  .push_valid              (push_valid),
  .push_data               (push_data),
  .processor_status_word   (processor_status_word),
  .instruction_pointer     (instruction_pointer),
  .jump_valid              (jump_valid),
  .jump_vector             (jump_vector),
  .new_segment             (new_segment),
  .new_status_word         (new_status_word),
  .segmented               (segmented),
  .sw_trap_number          (sw_trap_number),
  .hw_trap_req             (hw_trap_req),
  .cancel_instr            (cancel_instr)
);

`default_nettype wire
